/* rtl/ccm_pkg.sv */
// package: register map, mode encodings and field layout for the core clock mode select
package ccm_pkg;
  // apb register byte offsets
  localparam logic [7:0] ADDR_PIN_LATCH = 8'h00;
  localparam logic [7:0] ADDR_RESET_CTRL = 8'h04;
  localparam logic [7:0] ADDR_RELOAD = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0c;
  // mode field position inside the latch register
  localparam int MODE_HI = 7;
  localparam int MODE_LO = 5;
  // reset values
  localparam logic [7:0] PIN_LATCH_RST = 8'hff;
  localparam logic [15:0] RESET_CTRL_RST = 16'h0000;
  // reload command key in the low bit
  localparam int RELOAD_BIT = 0;
  // multiplier table in half steps (factor times 2); prescaler is 1 meaning 0.5
  localparam logic [3:0] HALF_X4 = 4'h8;
  localparam logic [3:0] HALF_X3 = 4'h6;
  localparam logic [3:0] HALF_X2 = 4'h4;
  localparam logic [3:0] HALF_X5 = 4'ha;
  localparam logic [3:0] HALF_X1 = 4'h2;
  localparam logic [3:0] HALF_X15 = 4'h3;
  localparam logic [3:0] HALF_D2 = 4'h1;
  localparam logic [3:0] HALF_X25 = 4'h5;

  typedef enum logic [2:0] {
    CCM_MUL_2P5 = 3'h0,
    CCM_PRESCALE = 3'h1,
    CCM_MUL_1P5 = 3'h2,
    CCM_DIRECT = 3'h3,
    CCM_MUL_5 = 3'h4,
    CCM_MUL_2 = 3'h5,
    CCM_MUL_3 = 3'h6,
    CCM_MUL_4 = 3'h7
  } ccm_mode_t;

  // decoded clock generation controls handed to the analog clock tree
  typedef struct packed {
    logic pll_enable;
    logic prescale_enable;
    logic direct_drive;
    logic [3:0] half_factor;
  } ccm_ctl_t;

  // apb slave request bundle
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } ccm_apb_req_t;
endpackage

/* rtl/ccm_mode_decode.sv */
// module: mode field to clock generation controls decoder
`timescale 1ns/100ps
module ccm_mode_decode
  import ccm_pkg::*;
(
  // mode in
  input wire ccm_pkg::ccm_mode_t mode,
  // decoded controls
  output ccm_pkg::ccm_ctl_t ctl
);
  // pure table; the pll is off only for direct drive and prescaler
  always_comb begin
    ctl = '0;
    unique case (mode)
      CCM_MUL_4: ctl.half_factor = HALF_X4;
      CCM_MUL_3: ctl.half_factor = HALF_X3;
      CCM_MUL_2: ctl.half_factor = HALF_X2;
      CCM_MUL_5: ctl.half_factor = HALF_X5;
      CCM_DIRECT: ctl.half_factor = HALF_X1;
      CCM_MUL_1P5: ctl.half_factor = HALF_X15;
      CCM_PRESCALE: ctl.half_factor = HALF_D2;
      CCM_MUL_2P5: ctl.half_factor = HALF_X25;
    endcase
    ctl.direct_drive = (mode == CCM_DIRECT);
    ctl.prescale_enable = (mode == CCM_PRESCALE);
    ctl.pll_enable = !(ctl.direct_drive || ctl.prescale_enable);
  end
endmodule

/* rtl/ccm_core.sv */
// module: core clock mode select with pin latch, software reload and apb registers
//
// Added by the designer: the APB interface to the registers and the placing of the registers.
`timescale 1ns/100ps
module ccm_core
  import ccm_pkg::*;
(
  // clock and long hardware reset
  input wire logic CLK,
  input wire logic RST_N,
  // upper half of the parallel port, sampled on reset release
  input wire logic [7:0] PORT_ZERO_UPPER_HALF,
  // apb slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // decoded clock generation controls
  output logic PLL_ENABLE,
  output logic PRESCALE_ENABLE,
  output logic DIRECT_DRIVE,
  output logic [3:0] HALF_FACTOR,
  output logic [2:0] CLOCK_MODE_SELECT
);
  import ccm_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // state
  typedef struct packed {
    logic strap_pending;
    logic [7:0] reset_pin_latch_high;
    logic [15:0] reset_control_register;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [6:0] outs;
  } ccm_state_t;

  ccm_state_t st;
  ccm_state_t next_st;
  ccm_apb_req_t req;
  ccm_ctl_t ctl;
  logic access;
  logic known;

  assign req = '{psel: PSEL, penable: PENABLE, pwrite: PWRITE, paddr: PADDR, pwdata: PWDATA};

  ////////////////////////////////////////////////////////////////////////////
  // decode of the next mode, so outputs change together with the latch
  ccm_mode_decode u_dec (
    .mode(ccm_mode_t'(next_st.reset_pin_latch_high[MODE_HI:MODE_LO])),
    .ctl(ctl)
  );

  ////////////////////////////////////////////////////////////////////////////
  // next state; apb answers in the setup cycle's following edge (one wait-free access)
  always_comb begin
    next_st = st;
    access = req.psel && !req.penable;
    known = (req.paddr == ADDR_PIN_LATCH) || (req.paddr == ADDR_RESET_CTRL) ||
            (req.paddr == ADDR_RELOAD) || (req.paddr == ADDR_STATUS);
    // strap capture one edge after reset release; an async reset may only load constants
    if (st.strap_pending) begin
      next_st.reset_pin_latch_high = PORT_ZERO_UPPER_HALF;
      next_st.strap_pending = 1'b0;
    end
    next_st.pready = access;
    next_st.pslverr = access && !known;
    if (access && req.pwrite && known) begin
      if (req.paddr == ADDR_RESET_CTRL) begin
        next_st.reset_control_register = req.pwdata[15:0];
      end
      // reload only on explicit command; apart from the strap capture the latch never moves otherwise
      if (req.paddr == ADDR_RELOAD && req.pwdata[RELOAD_BIT]) begin
        next_st.reset_pin_latch_high = st.reset_control_register[15:8];
      end
    end
    if (access && !req.pwrite) begin
      unique case (req.paddr)
        ADDR_PIN_LATCH: next_st.prdata = {24'h000000, st.reset_pin_latch_high};
        ADDR_RESET_CTRL: next_st.prdata = {16'h0000, st.reset_control_register};
        ADDR_STATUS: next_st.prdata = {25'h0000000, st.outs};
        default: next_st.prdata = 32'h00000000;
      endcase
    end
    next_st.outs = {ctl.pll_enable, ctl.prescale_enable, ctl.direct_drive, ctl.half_factor};
  end

  ////////////////////////////////////////////////////////////////////////////
  // register the whole state; reset gives default mode x4 with pll on
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      st.strap_pending <= 1'b1;
      st.reset_pin_latch_high <= PIN_LATCH_RST;
      st.reset_control_register <= RESET_CTRL_RST;
      st.prdata <= 32'h00000000;
      st.pready <= 1'b0;
      st.pslverr <= 1'b0;
      st.outs <= {1'b1, 1'b0, 1'b0, HALF_X4};
    end else begin
      st <= next_st;
    end
  end

  // outputs straight from flip-flops
  assign PRDATA = st.prdata;
  assign PREADY = st.pready;
  assign PSLVERR = st.pslverr;
  assign PLL_ENABLE = st.outs[6];
  assign PRESCALE_ENABLE = st.outs[5];
  assign DIRECT_DRIVE = st.outs[4];
  assign HALF_FACTOR = st.outs[3:0];
  assign CLOCK_MODE_SELECT = st.reset_pin_latch_high[MODE_HI:MODE_LO];

  ////////////////////////////////////////////////////////////////////////////
  // checks
  sequence s_reload_cmd;
    PSEL && !PENABLE && PWRITE && PADDR == ADDR_RELOAD && PWDATA[RELOAD_BIT];
  endsequence

  a_strap_capture: assert property (@(posedge CLK) disable iff (!RST_N)
    st.strap_pending |=> st.reset_pin_latch_high == $past(PORT_ZERO_UPPER_HALF))
    else $error("latch did not take the port pins");
  a_reload_loads: assert property (@(posedge CLK) disable iff (!RST_N)
    (!st.strap_pending) and s_reload_cmd |=>
      st.reset_pin_latch_high == $past(st.reset_control_register[15:8]))
    else $error("reload did not copy control register");
  a_mode_holds: assert property (@(posedge CLK) disable iff (!RST_N)
    !st.strap_pending && !(PSEL && !PENABLE && PWRITE && PADDR == ADDR_RELOAD) |=>
      $stable(CLOCK_MODE_SELECT))
    else $error("mode changed without reload");
  a_direct_no_pll: assert property (@(posedge CLK) disable iff (!RST_N)
    CLOCK_MODE_SELECT == 3'h3 |-> DIRECT_DRIVE && !PLL_ENABLE && HALF_FACTOR == HALF_X1)
    else $error("direct drive decode wrong");
  a_prescale_half: assert property (@(posedge CLK) disable iff (!RST_N)
    CLOCK_MODE_SELECT == 3'h1 |-> PRESCALE_ENABLE && !PLL_ENABLE && HALF_FACTOR == HALF_D2)
    else $error("prescaler decode wrong");
  a_pll_modes: assert property (@(posedge CLK) disable iff (!RST_N)
    CLOCK_MODE_SELECT != 3'h3 && CLOCK_MODE_SELECT != 3'h1 |-> PLL_ENABLE)
    else $error("pll not enabled in multiplying mode");
  a_default_x4: assert property (@(posedge CLK) disable iff (!RST_N)
    CLOCK_MODE_SELECT == 3'h7 |-> HALF_FACTOR == HALF_X4)
    else $error("default mode factor wrong");
  a_apb_answer: assert property (@(posedge CLK) disable iff (!RST_N)
    PSEL && !PENABLE |=> PREADY ##1 !PREADY)
    else $error("apb answer timing wrong");
endmodule

/* test/ccm_strap_model.sv */
// partner: board strap network on the upper port pins
`timescale 1ns/100ps
module ccm_strap_model #(
  parameter logic [7:0] STRAP = 8'h6a
) (
  input wire logic clk,
  input wire logic rst_n,
  output logic [7:0] pins
);
  logic [1:0] held;
  // straps hold through the latch edge, then the pins carry other traffic
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      held <= 2'h0;
    end else if (held != 2'h3) begin
      held <= held + 2'h1;
    end
  end
  assign pins = (held == 2'h3) ? ~STRAP : STRAP;
endmodule

/* test/tb_cpu_clock_mode_select.sv */
// testbench: strap latch, software reload, mode decode and apb refusal
`timescale 1ns/100ps
module tb_cpu_clock_mode_select;
  import ccm_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [7:0] pins;
  logic [31:0] prdata, rd;
  logic pready, pslverr, pll, pre, dir, er;
  logic [3:0] half;
  logic [2:0] mode;
  int fail_count = 0;
  int total_checks = 0;
  // direct drive strap keeps a 40 mhz source inside the core clock range
  ccm_strap_model #(.STRAP(8'h6a)) i_ccm_strap_model (.clk(clk), .rst_n(rst_n), .pins(pins));
  ccm_core i_ccm_core (.CLK(clk), .RST_N(rst_n), .PORT_ZERO_UPPER_HALF(pins), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .PLL_ENABLE(pll), .PRESCALE_ENABLE(pre),
    .DIRECT_DRIVE(dir), .HALF_FACTOR(half), .CLOCK_MODE_SELECT(mode));
  ////////////////////////////////////////////////////////////////////////////////
  // shared tasks
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: seen %h wanted %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // wait for the slave; only the watchdog ends a hung wait
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // controls expected for a mode, packed as {pll, pre, dir, half, mode}
  function automatic logic [31:0] ctl(input logic [2:0] m);
    logic [3:0] h;
    case (m)
      3'h0: h = HALF_X25;
      3'h1: h = HALF_D2;
      3'h2: h = HALF_X15;
      3'h3: h = HALF_X1;
      3'h4: h = HALF_X5;
      3'h5: h = HALF_X2;
      3'h6: h = HALF_X3;
      default: h = HALF_X4;
    endcase
    return {22'h0, m != 3'h1 && m != 3'h3, m == 3'h1, m == 3'h3, h, m};
  endfunction
  ////////////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic test_strap();
    @(negedge clk);
    chk({22'h0, pll, pre, dir, half, mode}, ctl(3'h3));
    apb(1'b0, ADDR_PIN_LATCH, 32'h0);
    chk(rd, 32'h6a);
    apb(1'b0, ADDR_RESET_CTRL, 32'h0);
    chk(rd, 32'h0);
  endtask
  task automatic test_modes();
    logic [31:0] exp;
    for (int m = 0; m < 8; m++) begin
      apb(1'b1, ADDR_RESET_CTRL, {16'h0, 3'(m), 5'h15, 8'h00});
      apb(1'b1, ADDR_RELOAD, 32'h1);
      apb(1'b0, ADDR_PIN_LATCH, 32'h0);
      chk(rd, {24'h0, 3'(m), 5'h15});
      chk({22'h0, pll, pre, dir, half, mode}, ctl(3'(m)));
      apb(1'b0, ADDR_STATUS, 32'h0);
      exp = ctl(3'(m));
      chk(rd, {25'h0, exp[9:3]});
    end
  endtask
  task automatic test_refuse();
    apb(1'b1, ADDR_RESET_CTRL, 32'h00002000);
    apb(1'b1, ADDR_RELOAD, 32'h0);
    apb(1'b1, ADDR_PIN_LATCH, 32'h0);
    apb(1'b1, 8'h10, 32'h1);
    chk({31'h0, er}, 32'h1);
    chk({22'h0, pll, pre, dir, half, mode}, ctl(3'h7));
    apb(1'b0, 8'h10, 32'h0);
    chk(rd, 32'h0);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // clock, watchdog, sequence and verdict
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    forever #12.5 clk = ~clk;
  end
  initial begin
    #(25 * 4000);
    fail_count++;
    stop_test();
  end
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    test_strap();
    test_modes();
    test_refuse();
    stop_test();
  end
endmodule
